// ===== aih_pkg.sv
// Purpose: shared constants and types for the analog input host exchange
// Assumes: 50 MHz ref_clk, Avalon-MM register access with waitrequest
// Notes:   map locations are 16-bit words, one per aligned 32-bit bus word
package aih_pkg;

  localparam int          CLK_HZ        = 50_000_000;
  localparam int          CYCLE_MS      = 25;
  localparam int          CYCLE_CLKS    = CLK_HZ / 1000 * CYCLE_MS;
  localparam int          BLINK_MS      = 500;
  localparam int          BLINK_CLKS    = CLK_HZ / 1000 * BLINK_MS;
  localparam int          FLASH_LIMIT   = 10_000;

  localparam int          NUM_INPUTS    = 16;
  localparam int          MAP_DEPTH     = 154;
  localparam logic [7:0]  MAP_LAST      = 8'h99;
  localparam logic [7:0]  RO_LAST       = 8'h2D;
  localparam logic [7:0]  RW_FIRST      = 8'h2E;
  localparam logic [7:0]  MAX_XFER      = 8'h7F;
  localparam logic [7:0]  SAMPLE_BASE   = 8'h00;
  localparam logic [7:0]  ENABLE_LOC    = 8'h2E;

  // bus window: byte addresses of the block registers
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STATUS    = 12'h004;
  localparam logic [11:0] OFF_POINTER   = 12'h008;
  localparam logic [11:0] OFF_COUNT     = 12'h00C;
  localparam logic [11:0] OFF_DATA      = 12'h010;
  localparam logic [11:0] OFF_RANGES    = 12'h014;
  localparam logic [11:0] OFF_SAVES     = 12'h018;

  // control word bit positions
  localparam int          CTL_SAVE_BIT  = 3;
  localparam int          CTL_COMMIT_BIT = 4;
  // status word bit positions
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_REJECT_BIT = 3;
  localparam int          ST_GOOD_BIT   = 7;

  localparam logic [31:0] BAD_ADDR_DATA = 32'hDEAD_BEEF;

  typedef enum logic [2:0] {
    RNG_0_10V, RNG_0_5V, RNG_PM5V, RNG_PM10V, RNG_0_20MA, RNG_PM20MA, RNG_BAD
  } aih_range_e;

  typedef struct packed {
    logic [3:0] pins;
    logic       current;
  } aih_switch_s;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [11:0] address;
    logic [31:0] writedata;
  } aih_req_s;

  function automatic aih_range_e decode_range(aih_switch_s sw);
    unique case (sw.pins)
      4'h0:    decode_range = sw.current ? RNG_BAD : RNG_0_10V;
      4'hC:    decode_range = sw.current ? RNG_0_20MA : RNG_0_5V;
      4'hF:    decode_range = sw.current ? RNG_PM20MA : RNG_PM5V;
      4'h3:    decode_range = sw.current ? RNG_BAD : RNG_PM10V;
      default: decode_range = RNG_BAD;
    endcase
  endfunction : decode_range

endpackage : aih_pkg

// ===== aih_nvm.sv
// Purpose: nonvolatile parameter store held in flip-flops
// Assumes: contents survive the block reset (only power loss clears them)
// Notes:   one word per cycle read or written by index
module aih_nvm (
  input  wire logic        ref_clk,
  input  wire logic        ce,
  input  wire logic        wr_en,
  input  wire logic [7:0]  idx,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data
);
  logic [15:0] mem_r [aih_pkg::MAP_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (ce && wr_en) begin
      mem_r[idx] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce) begin
      rd_data <= mem_r[idx];
    end
  end
endmodule : aih_nvm

// ===== aih_timer.sv
// Purpose: conversion cycle tick and unit-good blink generator
// Assumes: synchronous reset, clock enable freezes counting
// Notes:   tick is a one-cycle pulse every conversion period
module aih_timer (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic run,
  output logic      tick,
  output logic      blink
);
  logic [20:0] cyc_r;
  logic [24:0] blk_r;
  logic        blink_r;

  assign tick  = run && (cyc_r == 21'(aih_pkg::CYCLE_CLKS - 1));
  assign blink = blink_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cyc_r   <= '0;
      blk_r   <= '0;
      blink_r <= 1'b0;
    end else if (ce && run) begin
      cyc_r <= tick ? '0 : cyc_r + 21'h1;
      if (blk_r == 25'(aih_pkg::BLINK_CLKS - 1)) begin
        blk_r   <= '0;
        blink_r <= ~blink_r;
      end else begin
        blk_r <= blk_r + 25'h1;
      end
    end
  end
endmodule : aih_timer

// ===== aih_exchange.sv
// Purpose: host data exchange and parameter map of a 16-point analog input unit
// Assumes: Avalon-MM slave, 50 MHz ref_clk, synchronous active-high reset
// Notes:   samples arrive from the front end; this block only stores them
// How it works
// - four pins plus selector pick range
// - switches sampled once after power-up; this design resamples them at every block reset
// - control word in, status word out
// - init RAM, diagnose, then load parameters
// - host writes touch working RAM only
// - save request copies whole RAM set
// - map 000-153, 000-045 read-only monitoring
// - reads anywhere, writes only 046-153
// - at most 127 locations per transfer
// - convert enabled inputs every 25 ms
// - new parameters apply only after commit
// - pointer word picks first transfer location
// - save request is control bit 3
// - count saves, flash run beyond 10000
// - status bit 7 blinks at 1 Hz
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
module aih_exchange (
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire logic                     ce,
  input  wire logic [11:0]              avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  input  wire aih_pkg::aih_switch_s [15:0] switches,
  input  wire logic [15:0][15:0]        sample_in,
  input  wire logic                     diag_ok,
  output logic      [15:0]              enable_out,
  output logic                          convert_tick,
  output logic                          run_led
);
  typedef enum logic [2:0] {ST_INIT, ST_DIAG, ST_LOAD, ST_RUN, ST_SAVE, ST_FAIL} aih_state_e;

  aih_state_e  state_r, state_nxt;
  logic [7:0]  idx_r;
  logic [15:0] ram_r [aih_pkg::MAP_DEPTH];
  logic [15:0] act_enable_r;
  logic [15:0] stage_r [aih_pkg::NUM_INPUTS];
  logic [2:0]  range_r [aih_pkg::NUM_INPUTS];
  logic [7:0]  ptr_r;
  logic [7:0]  count_r;
  logic [7:0]  xfer_r;
  logic        reject_r;
  logic        commit_pend_r;
  logic [13:0] saves_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [15:0] nvm_q;
  logic        tick;
  logic        blink;
  logic        ld_valid_r;
  logic [7:0]  ld_idx_r;

  // bus decode
  wire access    = (avs_read || avs_write) && !ack_r && state_r == ST_RUN;
  wire wr_ctrl   = access && avs_write && avs_address == aih_pkg::OFF_CTRL;
  wire wr_ptr    = access && avs_write && avs_address == aih_pkg::OFF_POINTER;
  wire wr_count  = access && avs_write && avs_address == aih_pkg::OFF_COUNT;
  wire wr_data   = access && avs_write && avs_address == aih_pkg::OFF_DATA;
  wire rd_data   = access && avs_read && avs_address == aih_pkg::OFF_DATA;
  wire [7:0] loc = ptr_r + xfer_r;
  wire in_map    = loc <= aih_pkg::MAP_LAST;
  wire len_ok    = xfer_r < count_r && count_r <= aih_pkg::MAX_XFER;
  wire wr_ok     = in_map && loc >= aih_pkg::RW_FIRST && len_ok;
  wire rd_ok     = in_map && len_ok;
  wire save_req  = wr_ctrl && avs_writedata[aih_pkg::CTL_SAVE_BIT];
  wire commit    = wr_ctrl && avs_writedata[aih_pkg::CTL_COMMIT_BIT];
  wire running   = state_r == ST_RUN || state_r == ST_SAVE;

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata    = rdata_r;
  assign enable_out      = act_enable_r;
  assign convert_tick    = tick;
  assign run_led         = running && (saves_r > 14'(aih_pkg::FLASH_LIMIT) ? blink : 1'b1);

  aih_timer u_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .run     (running),
    .tick    (tick),
    .blink   (blink)
  );

  aih_nvm u_nvm (
    .ref_clk (ref_clk),
    .ce      (ce),
    .wr_en   (state_r == ST_SAVE),
    .idx     (idx_r),
    .wr_data (ram_r[idx_r]),
    .rd_data (nvm_q)
  );

  // sequencer: init, diagnose, load, run, save
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_INIT: if (idx_r == aih_pkg::MAP_LAST) state_nxt = ST_DIAG;
      ST_DIAG: state_nxt = diag_ok ? ST_LOAD : ST_FAIL;
      ST_LOAD: if (ld_valid_r && ld_idx_r == aih_pkg::MAP_LAST) state_nxt = ST_RUN;
      ST_RUN:  if (save_req) state_nxt = ST_SAVE;
      ST_SAVE: if (idx_r == aih_pkg::MAP_LAST) state_nxt = ST_RUN;
      ST_FAIL: state_nxt = ST_FAIL;
      default: state_nxt = ST_FAIL;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r    <= ST_INIT;
      idx_r      <= '0;
      ld_valid_r <= 1'b0;
      ld_idx_r   <= '0;
    end else if (ce) begin
      state_r    <= state_nxt;
      ld_valid_r <= state_r == ST_LOAD && idx_r <= aih_pkg::MAP_LAST;
      ld_idx_r   <= idx_r;
      if (state_nxt != state_r) begin
        idx_r <= '0;
      end else if (idx_r != 8'hFF) begin
        idx_r <= idx_r + 8'h01;
      end
    end
  end

  // working map
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      if (state_r == ST_INIT) begin
        ram_r[idx_r] <= '0;
      end else if (ld_valid_r && ld_idx_r >= aih_pkg::RW_FIRST) begin
        // only parameters come from the store; monitoring stays cleared
        ram_r[ld_idx_r] <= nvm_q;
      end else if (state_r == ST_RUN && tick) begin
        for (int i = 0; i < aih_pkg::NUM_INPUTS; i++) begin
          ram_r[aih_pkg::SAMPLE_BASE + 8'(i)] <= stage_r[i];
        end
      end else if (wr_data && wr_ok) begin
        ram_r[loc] <= avs_writedata[15:0];
      end
    end
  end

  // staging of samples; disabled inputs skipped
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      for (int i = 0; i < aih_pkg::NUM_INPUTS; i++) begin
        if (act_enable_r[i]) begin
          stage_r[i] <= sample_in[i];
        end
      end
    end
  end

  // switch capture once after reset release
  always_ff @(posedge ref_clk) begin
    if (ce && state_r == ST_INIT && idx_r == '0) begin
      for (int i = 0; i < aih_pkg::NUM_INPUTS; i++) begin
        range_r[i] <= 3'(aih_pkg::decode_range(switches[i]));
      end
    end
  end

  // transfer control and parameter commit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr_r         <= '0;
      count_r       <= aih_pkg::MAX_XFER;
      xfer_r        <= '0;
      reject_r      <= 1'b0;
      commit_pend_r <= 1'b0;
      act_enable_r  <= '0;
      saves_r       <= '0;
    end else if (ce) begin
      if (wr_ptr) begin
        ptr_r  <= avs_writedata[7:0];
        xfer_r <= '0;
      end
      if (wr_count) begin
        count_r <= avs_writedata[7:0];
        xfer_r  <= '0;
      end
      if ((wr_data || rd_data) && !wr_ptr && !wr_count) begin
        xfer_r <= xfer_r + 8'h01;
      end
      if (wr_data) begin
        reject_r <= !wr_ok;
      end
      if (wr_data && wr_ok) begin
        commit_pend_r <= 1'b1;
      end
      if (commit) begin
        act_enable_r  <= ram_r[aih_pkg::ENABLE_LOC];
        commit_pend_r <= 1'b0;
      end else if (state_r == ST_LOAD && state_nxt == ST_RUN) begin
        act_enable_r <= ram_r[aih_pkg::ENABLE_LOC];
      end
      if (save_req && saves_r != 14'h3FFF) begin
        saves_r <= saves_r + 14'h0001;
      end
    end
  end

  // read data and acknowledge
  wire [15:0] status_w = {8'h00, blink && running, 3'b000, reject_r, 2'b00,
                          state_r != ST_RUN};
  wire [15:0] rng_pack = {range_r[4][2:0], range_r[3][2:0], range_r[2][2:0],
                          range_r[1][2:0], range_r[0][2:0], 1'b0};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end else if (ce) begin
      ack_r <= access;
      if (access && avs_read) begin
        unique case (avs_address)
          aih_pkg::OFF_CTRL:    rdata_r <= {27'h0, commit_pend_r, 4'h0};
          aih_pkg::OFF_STATUS:  rdata_r <= {16'h0, status_w};
          aih_pkg::OFF_POINTER: rdata_r <= {24'h0, ptr_r};
          aih_pkg::OFF_COUNT:   rdata_r <= {24'h0, count_r};
          aih_pkg::OFF_DATA:    rdata_r <= rd_ok ? {16'h0, ram_r[loc]} : '0;
          aih_pkg::OFF_RANGES:  rdata_r <= {16'h0, rng_pack};
          aih_pkg::OFF_SAVES:   rdata_r <= {18'h0, saves_r};
          default:              rdata_r <= aih_pkg::BAD_ADDR_DATA;
        endcase
      end
    end
  end
endmodule : aih_exchange

// ===== aih_host.sv
// Purpose: host model issuing register transfers to the exchange block
// Assumes: Avalon-MM master, one request at a time
// Notes:   released address and data lines show the inverse of their last value; read and write drop low
module aih_host (
  input  wire logic        ref_clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic      [11:0] avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  timeunit 1ns;
  timeprecision 1ns;
  int waits;
  initial begin
    avs_address   = 12'h000;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end
  // one transfer at a time, so a read never overlaps a write
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    waits = 0;
    do begin
      @(posedge ref_clk);
      waits++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write     <= 1'b0;
    avs_read      <= 1'b0;
    avs_address   <= ~a;
    avs_writedata <= ~d;
  endtask : xfer
endmodule : aih_host

// ===== aih_exchange_properties.sv
// Purpose: port checks of the analog input host exchange
// Assumes: one clock domain, synchronous reset
// Notes:   conversion period is longer than a normal run
module aih_exchange_properties (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] enable_out,
  input wire logic        convert_tick,
  input wire logic        run_led
);
  localparam int TK_LO = aih_pkg::CYCLE_CLKS - 2;
  localparam int TK_HI = aih_pkg::CYCLE_CLKS + 400;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [9:0] up_r;
  logic [3:0] cm_r;
  int         tk_r;
  wire        commit = avs_write && !avs_waitrequest && avs_address == aih_pkg::OFF_CTRL
                       && avs_writedata[aih_pkg::CTL_COMMIT_BIT];
  always_ff @(posedge ref_clk) begin
    up_r <= reset ? 10'h000 : up_r + {9'h000, up_r != 10'h3FF};
    cm_r <= (reset || commit) ? 4'h0 : cm_r + {3'h0, cm_r != 4'hF};
    tk_r <= (reset || convert_tick) ? 0 : tk_r + int'(ce);
  end
  property p_wait_boot; (avs_read || avs_write) && up_r < 10'h096 |-> avs_waitrequest; endproperty
  a_wait_boot: assert property (p_wait_boot) else $error("request answered in startup");
  property p_led_boot; up_r < 10'h096 |-> !run_led; endproperty
  a_led_boot: assert property (p_led_boot) else $error("run lit during startup");
  property p_en_boot; up_r < 10'h096 |-> enable_out == 16'h0000; endproperty
  a_en_boot: assert property (p_en_boot) else $error("enables before load");
  property p_en_hold;
    $changed(enable_out) |-> up_r < 10'h190 || cm_r < 4'h8 || commit;
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enables moved without commit");
  property p_answer; (avs_read || avs_write) |-> ##[0:1000] !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("request never answered");
  property p_rd_hold; $changed(avs_readdata) |-> $past(avs_read); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 12'h01C
      |-> avs_readdata == aih_pkg::BAD_ADDR_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read value wrong");
  property p_tick_pulse; convert_tick && ce |=> !convert_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
  property p_tick_gap; convert_tick |-> tk_r inside {[TK_LO:TK_HI]}; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("conversion period wrong");
  c_commit: cover property (commit);
  c_unmapped: cover property (avs_read && !avs_waitrequest && avs_address == 12'h01C);
  c_stall: cover property (avs_write && avs_waitrequest [*8]);
endmodule : aih_exchange_properties

bind aih_exchange aih_exchange_properties u_props (
  .ref_clk(ref_clk), .reset(reset), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .enable_out(enable_out), .convert_tick(convert_tick), .run_led(run_led));

// ===== aih_exchange_bench.sv
// Purpose: self-checking bench of the analog input host exchange
// Assumes: host model drives the register bus
// Notes:   run is far shorter than one conversion period
module aih_exchange_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                           ref_clk, reset, ce, diag_ok, run_led, tick;
  logic [11:0]                    adr;
  logic                           rd_s, wr_s, wreq;
  logic [31:0]                    wdat, rdat, q;
  aih_pkg::aih_switch_s [15:0]    sw;
  logic [15:0][15:0]              smp;
  logic [15:0]                    en;
  int                             n_fail, n_checks;
  aih_exchange u_dut (.ref_clk(ref_clk), .reset(reset), .ce(ce), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .switches(sw), .sample_in(smp), .diag_ok(diag_ok),
    .enable_out(en), .convert_tick(tick), .run_led(run_led));
  aih_host u_host (.ref_clk(ref_clk), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd
  task automatic at(logic [7:0] loc, logic [7:0] n);
    wr(aih_pkg::OFF_POINTER, {24'h00_0000, loc});
    wr(aih_pkg::OFF_COUNT, {24'h00_0000, n});
  endtask : at
  task automatic put(logic [7:0] loc, logic [15:0] v);
    at(loc, 8'h01);
    wr(aih_pkg::OFF_DATA, {16'h0000, v});
  endtask : put
  task automatic get(logic [7:0] loc);
    at(loc, 8'h01);
    rd(aih_pkg::OFF_DATA);
  endtask : get
  task automatic rst();
    reset <= 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
  endtask : rst
  task automatic t_boot();
    rst();
    wr(aih_pkg::OFF_CTRL, 32'h0000_0000);
    chk("stall", 32'(u_host.waits >= 154), 32'h1);
    chk("run", {31'h0, run_led}, 32'h1);
    $display("t_boot done");
  endtask : t_boot
  task automatic t_map();
    at(8'h97, 8'h03);
    for (int i = 0; i < 3; i++) wr(aih_pkg::OFF_DATA, 32'h0000_A000 + i);
    at(8'h97, 8'h03);
    for (int i = 0; i < 3; i++) begin
      rd(aih_pkg::OFF_DATA);
      chk("map", q[15:0], 16'hA000 + 16'(i));
    end
    rd(aih_pkg::OFF_DATA);
    chk("past count", q, 32'h0000_0000);
    rd(aih_pkg::OFF_STATUS);
    chk("accept", {31'h0, q[aih_pkg::ST_REJECT_BIT]}, 32'h0);
    $display("t_map done");
  endtask : t_map
  task automatic t_reject();
    logic [15:0] old;
    get(8'h2D);
    old = q[15:0];
    put(8'h2D, 16'h1111);
    rd(aih_pkg::OFF_STATUS);
    chk("reject", {31'h0, q[aih_pkg::ST_REJECT_BIT]}, 32'h1);
    get(8'h2D);
    chk("ro init", old, 16'h0000);
    chk("ro kept", q[15:0], 16'h0000);
    put(8'h41, 16'h2222);
    at(8'h40, 8'h01);
    wr(aih_pkg::OFF_DATA, 32'h0000_3333);
    wr(aih_pkg::OFF_DATA, 32'h0000_4444);
    get(8'h41);
    chk("over count", q[15:0], 16'h2222);
    rd(12'h01C);
    chk("unmapped", q, aih_pkg::BAD_ADDR_DATA);
    $display("t_reject done");
  endtask : t_reject
  task automatic t_commit();
    put(aih_pkg::ENABLE_LOC, 16'h0003);
    wr(aih_pkg::OFF_CTRL, 32'h0000_0010);
    wr(aih_pkg::OFF_CTRL, 32'h0000_0000);
    put(aih_pkg::ENABLE_LOC, 16'h00A5);
    repeat (20) @(posedge ref_clk);
    chk("held", en, 16'h0003);
    wr(aih_pkg::OFF_CTRL, 32'h0000_0010);
    repeat (10) @(posedge ref_clk);
    chk("applied", en, 16'h00A5);
    wr(aih_pkg::OFF_CTRL, 32'h0000_0000);
    $display("t_commit done");
  endtask : t_commit
  task automatic t_save();
    logic [31:0] n0;
    rd(aih_pkg::OFF_SAVES);
    n0 = q;
    put(aih_pkg::ENABLE_LOC, 16'h5A5A);
    wr(aih_pkg::OFF_CTRL, 32'h0000_0008);
    wr(aih_pkg::OFF_CTRL, 32'h0000_0000);
    rd(aih_pkg::OFF_SAVES);
    chk("saves", q, n0 + 1);
    put(aih_pkg::ENABLE_LOC, 16'h1234);
    rst();
    get(aih_pkg::ENABLE_LOC);
    chk("stored", q[15:0], 16'h5A5A);
    chk("loaded", en, 16'h5A5A);
    $display("t_save done");
  endtask : t_save
  task automatic t_ranges();
    logic [31:0] r0;
    rd(aih_pkg::OFF_RANGES);
    r0 = q;
    for (int i = 0; i < 16; i++) sw[i] <= '{pins: 4'h0, current: 1'b0};
    repeat (5) @(posedge ref_clk);
    rd(aih_pkg::OFF_RANGES);
    chk("ranges", q, r0);
    $display("t_ranges done");
  endtask : t_ranges
  task automatic t_diag();
    diag_ok <= 1'b0;
    rst();
    repeat (500) @(posedge ref_clk);
    chk("fail dark", {31'h0, run_led}, 32'h0);
    diag_ok <= 1'b1;
    t_boot();
    $display("t_diag done");
  endtask : t_diag
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  logic [4:0] codes [6] = '{5'h18, 5'h00, 5'h1E, 5'h06, 5'h19, 5'h1F};
  initial begin
    {n_fail, n_checks} = '0;
    {reset, ce, diag_ok} = 3'b111;
    for (int i = 0; i < 16; i++) sw[i] = codes[i % 6];
    for (int i = 0; i < 16; i++) smp[i] = 16'h0100 + 16'(i);
    t_boot();
    t_map();
    t_reject();
    t_commit();
    t_save();
    t_ranges();
    t_diag();
    close_out();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    close_out();
  end
endmodule : aih_exchange_bench
